/* File: include/mspc_pkg.sv */
package mspc_pkg;
	// Register byte offsets on the AXI4-Lite port
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_RXDATA = 8'h10;
	localparam logic [7:0] ADDR_TXDATA = 8'h14;
	// Control word and data register fields
	localparam int CTRL_NODE_LSB = 0;
	localparam int CTRL_BAUD_LSB = 8;
	localparam int CTRL_PROTO_LSB = 10;
	localparam int CTRL_FAULT_LSB = 13;
	localparam int TX_SOF_BIT = 8;
	localparam int TX_EOF_BIT = 9;
	localparam int RX_VALID_BIT = 8;
	localparam int RX_BCAST_BIT = 9;
	// Status / mask bit positions
	localparam int ST_RX_BYTE = 0;
	localparam int ST_FRAME = 1;
	localparam int ST_TX_DONE = 2;
	localparam int ST_ERR = 3;
	localparam int ST_TMO = 4;
	localparam int ST_W = 5;
	// Reset values, limits and the first RTU protocol code
	localparam logic [7:0] NODE_RST = 8'h01;
	localparam logic [7:0] NODE_MAX = 8'hFE;
	localparam logic [1:0] BAUD_RST = 2'h1;
	localparam logic [2:0] PROTO_RST = 3'h0;
	localparam logic [2:0] PROTO_MAX = 3'h5;
	localparam logic [2:0] PROTO_RTU0 = 3'h3;
	localparam logic [1:0] FAULT_RST = 2'h3;
	localparam logic [9:0] TMO_RST = 10'h000;
	localparam logic [9:0] TMO_MAX = 10'h258;
	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int BAUD_0 = 4800;
	localparam int BAUD_1 = 9600;
	localparam int BAUD_2 = 19200;
	localparam int BAUD_3 = 38400;
	localparam int SILENCE_MS = 10;
	localparam int SILENCE_CYC = SILENCE_MS * (CLK_HZ / 1000);
	localparam int TENTH_MS = 100;
	localparam int TENTH_CYC = TENTH_MS * (CLK_HZ / 1000);
	// Frame characters, broadcast address and response codes
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic eight;
		logic par_en;
		logic par_odd;
		logic two_stop;
	} mspc_fmt_t;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_ADDR = 2'b01,
		FR_BODY = 2'b11,
		FR_DROP = 2'b10
	} mspc_fr_t;

	function automatic mspc_fmt_t fmt_of(input logic [2:0] p);
		mspc_fmt_t f;
		f.eight = (p >= PROTO_RTU0);
		f.par_en = (p != 3'h0) && (p != 3'h3);
		f.par_odd = (p == 3'h2) || (p == 3'h5);
		f.two_stop = !f.par_en;
		return f;
	endfunction

	function automatic logic [13:0] baud_div(input logic [1:0] b);
		case (b)
			2'h0: baud_div = 14'(CLK_HZ / BAUD_0);
			2'h1: baud_div = 14'(CLK_HZ / BAUD_1);
			2'h2: baud_div = 14'(CLK_HZ / BAUD_2);
			default: baud_div = 14'(CLK_HZ / BAUD_3);
		endcase
	endfunction

	function automatic logic [4:0] hex_dec(input logic [7:0] c);
		if (c >= CH_ZERO && c <= CH_NINE)
			hex_dec = {1'b1, 4'(c - CH_ZERO)};
		else if (c >= CH_A && c <= CH_F)
			hex_dec = {1'b1, 4'(c - CH_A + 8'h0A)};
		else
			hex_dec = 5'h00;
	endfunction

	function automatic logic [7:0] hex_enc(input logic [3:0] n);
		hex_enc = (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_A + {4'h0, n} - 8'h0A);
	endfunction

	function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			strb_merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
	endfunction
endpackage

/* File: src/mspc_port.sv */
`timescale 1ns/1ps
`default_nettype none
module mspc_port #(
	parameter int SILENCE_CYCLES = mspc_pkg::SILENCE_CYC,
	parameter int TENTH_CYCLES = mspc_pkg::TENTH_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// AXI4-Lite slave
	input wire logic s_axi_awvalid_i,
	input wire logic [7:0] s_axi_awaddr_i,
	output logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_wready_o,
	output logic s_axi_bvalid_o,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic [7:0] s_axi_araddr_i,
	output logic s_axi_arready_o,
	output logic s_axi_rvalid_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rready_i,
	// RS-485 line
	input wire logic rxd_i,
	output logic txd_o,
	output logic txd_oe_o,
	// Drive reaction
	output logic irq_o,
	output logic comm_timeout_error_code_o,
	output logic warn_o,
	output logic ramp_stop_o,
	output logic coast_stop_o
);
	import mspc_pkg::*;

	logic [7:0] node_address_setting;
	logic [1:0] baud_setting;
	logic [2:0] protocol_format_setting;
	logic [1:0] fault_treatment_setting;
	logic [9:0] bus_timeout_setting;
	logic [ST_W-1:0] status, irq_mask, ev;
	logic ev_rx, ev_frame, ev_err, ev_tx, ev_tmo;
	mspc_fmt_t fmt;
	logic ascii_mode;
	logic [13:0] bit_div;
	logic [3:0] char_len;

	assign fmt = fmt_of(protocol_format_setting);
	assign ascii_mode = protocol_format_setting < PROTO_RTU0;
	assign bit_div = baud_div(baud_setting);
	assign char_len = 4'(1 + (fmt.eight ? 8 : 7) + (fmt.par_en ? 1 : 0) + (fmt.two_stop ? 2 : 1));

	// AXI4-Lite: address and data latched independently, answered once both held
	logic aw_hold, w_hold, wr_fire, rd_fire;
	logic [7:0] aw_addr;
	logic [31:0] w_data, wr_val, rd_val, ctrl_word;
	logic [3:0] w_strb;
	logic [7:0] rx_data;
	logic rx_valid, bcast;

	assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid_o;
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
	assign ctrl_word = {17'h0, fault_treatment_setting, protocol_format_setting, baud_setting,
		node_address_setting};
	assign wr_val = strb_merge(aw_addr == ADDR_CTRL ? ctrl_word : 32'h0, w_data, w_strb);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr[7:2] <= ADDR_TXDATA[7:2] && aw_addr[1:0] == 2'h0) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_comb begin
		case (s_axi_araddr_i)
			ADDR_CTRL: rd_val = ctrl_word;
			ADDR_TIMEOUT: rd_val = {22'h0, bus_timeout_setting};
			ADDR_STATUS: rd_val = {27'h0, status};
			ADDR_MASK: rd_val = {27'h0, irq_mask};
			ADDR_RXDATA: rd_val = {22'h0, bcast, rx_valid, rx_data};
			ADDR_TXDATA: rd_val = 32'h0;
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_val;
			s_axi_rresp_o <= (s_axi_araddr_i[7:2] <= ADDR_TXDATA[7:2] &&
				s_axi_araddr_i[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// Configuration; out-of-range values leave the field untouched
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			node_address_setting <= NODE_RST;
			baud_setting <= BAUD_RST;
			protocol_format_setting <= PROTO_RST;
			fault_treatment_setting <= FAULT_RST;
			bus_timeout_setting <= TMO_RST;
			irq_mask <= '0;
		end else if (wr_fire) begin
			if (aw_addr == ADDR_CTRL) begin
				if (wr_val[CTRL_NODE_LSB +: 8] != 8'h00 && wr_val[CTRL_NODE_LSB +: 8] <= NODE_MAX)
					node_address_setting <= wr_val[CTRL_NODE_LSB +: 8];
				baud_setting <= wr_val[CTRL_BAUD_LSB +: 2];
				if (wr_val[CTRL_PROTO_LSB +: 3] <= PROTO_MAX)
					protocol_format_setting <= wr_val[CTRL_PROTO_LSB +: 3];
				fault_treatment_setting <= wr_val[CTRL_FAULT_LSB +: 2];
			end
			if (aw_addr == ADDR_TIMEOUT && wr_val[9:0] <= TMO_MAX)
				bus_timeout_setting <= wr_val[9:0];
			if (aw_addr == ADDR_MASK)
				irq_mask <= wr_val[ST_W-1:0];
		end
	end

	// Sticky status; a new event beats a same-cycle write-one-to-clear
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			status <= '0;
		else
			status <= (status & ~((wr_fire && aw_addr == ADDR_STATUS) ? wr_val[ST_W-1:0] : '0)) | ev;
	end
	assign irq_o = |(status & irq_mask);
	assign ev = {ev_tmo, ev_err, ev_tx, ev_frame, ev_rx};

	// Receiver: sample mid-bit, counting from the start edge
	logic rx_busy, rx_done, rx_bad, par_bit, stop_ok;
	logic [13:0] rx_cnt;
	logic [3:0] rx_idx;
	logic [10:0] rx_sh;
	logic [7:0] rx_char;
	logic [4:0] hx;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_busy <= 1'b0;
			rx_cnt <= 14'h0;
			rx_idx <= 4'h0;
			rx_sh <= 11'h7FF;
			rx_done <= 1'b0;
		end else begin
			rx_done <= rx_busy && rx_cnt == 14'h0 && rx_idx == char_len - 4'h1;
			if (!rx_busy) begin
				if (!rxd_i) begin
					rx_busy <= 1'b1;
					rx_cnt <= bit_div >> 1;
					rx_idx <= 4'h0;
				end
			end else if (rx_cnt == 14'h0) begin
				rx_sh[rx_idx] <= rxd_i;
				rx_cnt <= bit_div;
				if (rx_idx == char_len - 4'h1)
					rx_busy <= 1'b0;
				else
					rx_idx <= rx_idx + 4'h1;
			end else begin
				rx_cnt <= rx_cnt - 14'h1;
			end
		end
	end

	assign rx_char = fmt.eight ? rx_sh[8:1] : {1'b0, rx_sh[7:1]};
	assign par_bit = fmt.eight ? rx_sh[9] : rx_sh[8];
	assign stop_ok = rx_sh[char_len - 4'h1] && (!fmt.two_stop || rx_sh[char_len - 4'h2]);
	assign rx_bad = rx_sh[0] || !stop_ok || (fmt.par_en && ((^{rx_char, par_bit}) != fmt.par_odd));
	assign hx = hex_dec(rx_char);

	// Line silence, shared by RTU framing and reply spacing
	logic [$clog2(SILENCE_CYCLES+1)-1:0] gap_cnt;
	logic gap_full, ser_busy;
	assign gap_full = gap_cnt == ($bits(gap_cnt))'(SILENCE_CYCLES);
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			gap_cnt <= '0;
		else if (rx_busy || ser_busy)
			gap_cnt <= '0;
		else if (!gap_full)
			gap_cnt <= gap_cnt + 1'b1;
	end

	// Frame layer
	mspc_fr_t fr_state;
	logic nib_phase, cr_seen, got_byte;
	logic [3:0] hi_nib;
	logic [7:0] byte_val;

	always_comb begin
		got_byte = 1'b0;
		byte_val = 8'h00;
		if (rx_done && !rx_bad) begin
			if (ascii_mode) begin
				if ((fr_state == FR_ADDR || fr_state == FR_BODY) && hx[4] && nib_phase && !cr_seen) begin
					got_byte = 1'b1;
					byte_val = {hi_nib, hx[3:0]};
				end
			end else if (fr_state != FR_DROP) begin
				got_byte = 1'b1;
				byte_val = rx_char;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fr_state <= FR_IDLE;
			nib_phase <= 1'b0;
			cr_seen <= 1'b0;
			hi_nib <= 4'h0;
			bcast <= 1'b0;
			ev_rx <= 1'b0;
			ev_frame <= 1'b0;
			ev_err <= 1'b0;
		end else begin
			ev_rx <= 1'b0;
			ev_frame <= 1'b0;
			ev_err <= 1'b0;
			if (rx_done && rx_bad) begin
				fr_state <= FR_DROP;
				ev_err <= 1'b1;
			end else if (got_byte) begin
				nib_phase <= 1'b0;
				if (fr_state == FR_BODY) begin
					ev_rx <= 1'b1;
				end else if (byte_val == node_address_setting || byte_val == BCAST_ADDR) begin
					fr_state <= FR_BODY;
					bcast <= byte_val == BCAST_ADDR;
				end else begin
					fr_state <= FR_DROP;
				end
			end else if (rx_done && ascii_mode) begin
				case (fr_state)
					FR_IDLE, FR_DROP: begin
						if (rx_char == CH_COLON) begin
							fr_state <= FR_ADDR;
							nib_phase <= 1'b0;
							cr_seen <= 1'b0;
						end
					end
					default: begin
						if (rx_char == CH_COLON) begin
							fr_state <= FR_ADDR;
							nib_phase <= 1'b0;
							cr_seen <= 1'b0;
						end else if (rx_char == CH_CR && !cr_seen) begin
							cr_seen <= 1'b1;
						end else if (rx_char == CH_LF && cr_seen) begin
							fr_state <= FR_IDLE;
							ev_frame <= fr_state == FR_BODY;
						end else if (hx[4] && !cr_seen && !nib_phase) begin
							hi_nib <= hx[3:0];
							nib_phase <= 1'b1;
						end else begin
							fr_state <= FR_DROP;
							ev_err <= 1'b1;
						end
					end
				endcase
			end else if (!ascii_mode && gap_full && fr_state != FR_IDLE) begin
				fr_state <= FR_IDLE;
				ev_frame <= fr_state == FR_BODY;
			end
		end
	end

	// Received data holding register; read clears valid unless a byte lands
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else if (got_byte && fr_state == FR_BODY) begin
			rx_data <= byte_val;
			rx_valid <= 1'b1;
		end else if (rd_fire && s_axi_araddr_i == ADDR_RXDATA) begin
			rx_valid <= 1'b0;
		end
	end

	// Transmitter: phases 0 colon, 1 high hex, 2 low hex or raw, 3 CR, 4 LF, 5 done
	logic tx_busy, tx_eof, tx_sof, tx_load, tx_wr;
	logic [7:0] tx_byte, tx_char;
	logic [2:0] tx_phase;
	logic [13:0] tx_cnt;
	logic [3:0] tx_left;
	logic [10:0] tx_sh, tx_frame;

	assign ser_busy = tx_left != 4'h0;
	assign tx_wr = wr_fire && aw_addr == ADDR_TXDATA;
	assign tx_load = tx_busy && !ser_busy && tx_phase != 3'h5 && (ascii_mode || !tx_sof || gap_full);
	always_comb begin
		case (tx_phase)
			3'h0: tx_char = CH_COLON;
			3'h1: tx_char = hex_enc(tx_byte[7:4]);
			3'h2: tx_char = ascii_mode ? hex_enc(tx_byte[3:0]) : tx_byte;
			3'h3: tx_char = CH_CR;
			default: tx_char = CH_LF;
		endcase
		tx_frame = '1;
		if (fmt.eight)
			tx_frame[9:0] = {fmt.par_en ? (^tx_char ^ fmt.par_odd) : 1'b1, tx_char, 1'b0};
		else
			tx_frame[8:0] = {fmt.par_en ? (^tx_char[6:0] ^ fmt.par_odd) : 1'b1, tx_char[6:0], 1'b0};
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_busy <= 1'b0;
			tx_byte <= 8'h00;
			tx_sof <= 1'b0;
			tx_eof <= 1'b0;
			tx_phase <= 3'h5;
			ev_tx <= 1'b0;
		end else begin
			ev_tx <= 1'b0;
			if (!tx_busy && tx_wr && !bcast) begin
				tx_busy <= 1'b1;
				tx_byte <= wr_val[7:0];
				tx_sof <= wr_val[TX_SOF_BIT];
				tx_eof <= wr_val[TX_EOF_BIT];
				tx_phase <= !ascii_mode ? 3'h2 : (wr_val[TX_SOF_BIT] ? 3'h0 : 3'h1);
			end else if (tx_load) begin
				if (tx_phase == 3'h4 || (tx_phase == 3'h2 && (!ascii_mode || !tx_eof)))
					tx_phase <= 3'h5;
				else
					tx_phase <= tx_phase + 3'h1;
			end else if (tx_busy && !ser_busy && tx_phase == 3'h5) begin
				tx_busy <= 1'b0;
				ev_tx <= 1'b1;
			end
		end
	end

	// Serialiser; idle shifts in ones so the line rests high
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_sh <= 11'h7FF;
			tx_left <= 4'h0;
			tx_cnt <= 14'h0;
		end else if (tx_load) begin
			tx_sh <= tx_frame;
			tx_left <= char_len;
			tx_cnt <= bit_div;
		end else if (ser_busy) begin
			if (tx_cnt == 14'h0) begin
				tx_sh <= {1'b1, tx_sh[10:1]};
				tx_left <= tx_left - 4'h1;
				tx_cnt <= bit_div;
			end else begin
				tx_cnt <= tx_cnt - 14'h1;
			end
		end
	end
	assign txd_o = tx_sh[0];
	assign txd_oe_o = tx_busy;

	// Bus-silence supervisor counted in tenths of a second
	logic [$clog2(TENTH_CYCLES)-1:0] tenth_cnt;
	logic [9:0] tenths;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tenth_cnt <= '0;
			tenths <= 10'h0;
			ev_tmo <= 1'b0;
		end else begin
			ev_tmo <= 1'b0;
			if (rx_done) begin
				tenth_cnt <= '0;
				tenths <= 10'h0;
			end else if (tenth_cnt == ($bits(tenth_cnt))'(TENTH_CYCLES - 1)) begin
				tenth_cnt <= '0;
				if (tenths != 10'h3FF)
					tenths <= tenths + 10'h1;
				if (bus_timeout_setting != 10'h0 && fault_treatment_setting != 2'h3 &&
						tenths + 10'h1 == bus_timeout_setting)
					ev_tmo <= 1'b1;
			end else begin
				tenth_cnt <= tenth_cnt + 1'b1;
			end
		end
	end

	assign comm_timeout_error_code_o = status[ST_TMO];
	assign warn_o = (status[ST_ERR] || status[ST_TMO]) && fault_treatment_setting != 2'h3;
	assign ramp_stop_o = (status[ST_ERR] || status[ST_TMO]) && fault_treatment_setting == 2'h1;
	assign coast_stop_o = (status[ST_ERR] || status[ST_TMO]) && fault_treatment_setting == 2'h2;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	node_range_a: assert property (node_address_setting != 8'h00 && node_address_setting <= NODE_MAX)
		else $error("node address out of range");
	addr_filter_a: assert property (got_byte && fr_state != FR_BODY && byte_val != BCAST_ADDR &&
		byte_val != node_address_setting |=> fr_state == FR_DROP)
		else $error("foreign frame not dropped");
	bit_time_a: assert property (tx_load |=> tx_cnt == bit_div && tx_left == char_len)
		else $error("bit timing not loaded");
	fault_act_a: assert property (status[ST_ERR] |-> (warn_o == (fault_treatment_setting != 2'h3)) &&
		(ramp_stop_o == (fault_treatment_setting == 2'h1)))
		else $error("fault reaction wrong");
	tmo_cause_a: assert property ($rose(status[ST_TMO]) |-> $past(bus_timeout_setting, 2) != 10'h0 &&
		$past(fault_treatment_setting, 2) != 2'h3)
		else $error("timeout raised while disabled");
	tmo_flag_a: assert property (ev[ST_TMO] |=> comm_timeout_error_code_o)
		else $error("timeout error not shown");
	proto_range_a: assert property (protocol_format_setting <= PROTO_MAX)
		else $error("protocol code out of range");
	hex_char_a: assert property (tx_load && ascii_mode && (tx_phase == 3'h1 || tx_phase == 3'h2) |->
		(tx_char >= CH_ZERO && tx_char <= CH_NINE) || (tx_char >= CH_A && tx_char <= CH_F))
		else $error("non-hex character sent");
	raw_char_a: assert property (tx_load && !ascii_mode |-> tx_char == tx_byte && tx_phase == 3'h2)
		else $error("rtu byte altered");
	bcast_mute_a: assert property (bcast && !tx_busy && tx_wr |=> !tx_busy [*2])
		else $error("reply to broadcast");
	rtu_end_a: assert property (!ascii_mode && gap_full && fr_state == FR_BODY && !rx_done |=>
		fr_state == FR_IDLE && ev[ST_FRAME])
		else $error("rtu silence did not end frame");
	bad_char_a: assert property (rx_done && rx_bad |=> fr_state == FR_DROP && ev[ST_ERR])
		else $error("bad character not discarded");
	bcast_frame_c: cover property (got_byte && fr_state == FR_ADDR && byte_val == BCAST_ADDR);
	ascii_end_c: cover property (ascii_mode && ev[ST_FRAME]);
	rtu_end_c: cover property (!ascii_mode && ev[ST_FRAME]);
	timeout_c: cover property (ev[ST_TMO]);
endmodule
`default_nettype wire

/* File: verif/mspc_master.sv */
`timescale 1ns/1ps
`default_nettype none
module mspc_master
	import mspc_pkg::*;
#(
	parameter int BIT_CYC = CLK_HZ / BAUD_3 + 1
) (
	// Clock
	input wire logic mclk_i,
	// Line
	input wire logic line_i,
	output logic rxd_o
);
	initial begin
		rxd_o = 1'b1;
	end
	// 8N2 only: start, data LSB first, two stops
	task automatic send(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd_o <= f[i];
			repeat (BIT_CYC) @(posedge mclk_i);
		end
	endtask
	// Sampled on falling edges, clear of the launch edge
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (line_i !== 1'b0 && n < 20000) begin
			@(negedge mclk_i);
			n++;
		end
		repeat (BIT_CYC / 2) @(negedge mclk_i);
		ok = (n < 20000) && (line_i === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(negedge mclk_i);
			b[i] = line_i;
		end
		repeat (BIT_CYC) @(negedge mclk_i);
		ok = ok && (line_i === 1'b1);
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
	import mspc_pkg::*;
	localparam int SIL = 2000;
	localparam int BITC = CLK_HZ / BAUD_3 + 1;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [3:0] ws = 4'hF;
	logic [31:0] wd = 32'h0, rdat;
	logic [1:0] bresp, rresp, resp;
	wire logic awr, wr_rdy, bv, arr, rv, txd, oe, irq, tmo, warn, ramp, coast, rxd, line;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	assign line = oe ? txd : 1'b1;
	always #12.5 mclk_i = ~mclk_i;
	mspc_port #(.SILENCE_CYCLES(SIL), .TENTH_CYCLES(100)) mspc_port_inst (.mclk_i(mclk_i),
		.rstn_i(rstn_i), .s_axi_awvalid_i(awv), .s_axi_awaddr_i(awa), .s_axi_awready_o(awr),
		.s_axi_wvalid_i(wv), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wready_o(wr_rdy),
		.s_axi_bvalid_o(bv), .s_axi_bresp_o(bresp), .s_axi_bready_i(bry),
		.s_axi_arvalid_i(arv), .s_axi_araddr_i(ara), .s_axi_arready_o(arr),
		.s_axi_rvalid_o(rv), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
		.s_axi_rready_i(rry), .rxd_i(rxd), .txd_o(txd), .txd_oe_o(oe), .irq_o(irq),
		.comm_timeout_error_code_o(tmo), .warn_o(warn), .ramp_stop_o(ramp),
		.coast_stop_o(coast));
	mspc_master mspc_master_inst (.mclk_i(mclk_i), .line_i(line), .rxd_o(rxd));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge mclk_i);
			ta = awv && awr;
			tw = wv && wr_rdy;
			tb = bv;
			resp = bresp;
			@(posedge mclk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) bry <= 1'b0;
		end
		// Idle edge so a following call never re-raises bready in this step
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic ta, tr;
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge mclk_i);
			ta = arv && arr;
			tr = rv;
			q = rdat;
			resp = rresp;
			@(posedge mclk_i);
			if (ta) arv <= 1'b0;
			if (tr) rry <= 1'b0;
		end
		@(posedge mclk_i);
	endtask
	task automatic t_regs;
		logic [31:0] q;
		rd(ADDR_CTRL, q);
		`CHK(q, {17'h0, FAULT_RST, PROTO_RST, BAUD_RST, NODE_RST})
		rd(8'h20, q);
		`CHK(resp, RESP_SLVERR)
		wr(ADDR_CTRL, 32'h00000F12);
		wr(ADDR_CTRL, 32'h00000F00);
		rd(ADDR_CTRL, q);
		`CHK(q, 32'h00000F12)
		// Only the node byte is strobed; the rest keeps its value
		ws <= 4'h1;
		wr(ADDR_CTRL, 32'h00000056);
		ws <= 4'hF;
		rd(ADDR_CTRL, q);
		`CHK(q, 32'h00000F56)
		wr(ADDR_CTRL, 32'h00000F12);
		wr(ADDR_MASK, 32'h00000002);
	endtask
	task automatic t_rx_own;
		logic [31:0] q;
		mspc_master_inst.send(8'h12);
		mspc_master_inst.send(8'hA5);
		repeat (SIL + BITC) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHK(irq, 1'b1)
		@(posedge mclk_i);
		rd(ADDR_RXDATA, q);
		`CHK(q[9:0], 10'h1A5)
		rd(ADDR_STATUS, q);
		`CHK(q[1:0], 2'b11)
		wr(ADDR_STATUS, 32'h0000001F);
		@(negedge mclk_i);
		`CHK(irq, 1'b0)
		`CHK(tmo, 1'b0)
		@(posedge mclk_i);
	endtask
	task automatic t_rx_other;
		logic [31:0] q;
		// Supervision armed: the traffic below restarts the silence count
		wr(ADDR_TIMEOUT, 32'h00000001);
		mspc_master_inst.send(8'h34);
		mspc_master_inst.send(8'h77);
		repeat (SIL + BITC) @(posedge mclk_i);
		rd(ADDR_RXDATA, q);
		`CHK(q[8], 1'b0)
		rd(ADDR_STATUS, q);
		`CHK(q[1], 1'b0)
		@(negedge mclk_i);
		`CHK(tmo, 1'b1)
		@(posedge mclk_i);
	endtask
	task automatic t_tx;
		logic [7:0] b;
		logic ok;
		logic [31:0] q;
		wr(ADDR_TXDATA, 32'h0000033C);
		mspc_master_inst.recv(b, ok);
		`CHK(ok, 1'b1)
		`CHK(b, 8'h3C)
		repeat (2 * BITC) @(posedge mclk_i);
		rd(ADDR_STATUS, q);
		`CHK(q[2], 1'b1)
	endtask
	task automatic t_bcast;
		logic seen;
		seen = 1'b0;
		mspc_master_inst.send(BCAST_ADDR);
		repeat (SIL + BITC) @(posedge mclk_i);
		wr(ADDR_TXDATA, 32'h00000355);
		repeat (SIL + 2 * BITC) begin
			@(negedge mclk_i);
			seen = seen | oe;
		end
		`CHK(seen, 1'b0)
		// Fault code 3 must keep supervision quiet even when enabled
		`CHK(tmo, 1'b0)
		@(posedge mclk_i);
	endtask
	task automatic t_tmo;
		logic [2:0] got, want;
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_CTRL, 32'h00000F12 | (f << 13));
			@(negedge mclk_i);
			got = {warn, ramp, coast};
			want = {f != 3, f == 1, f == 2};
			`CHK(got, want)
			@(posedge mclk_i);
		end
		// Leaves fault code 3 armed with the timeout flag cleared for the broadcast test
		wr(ADDR_STATUS, 32'h00000010);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			bad_count++;
			conclude;
		end
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		t_regs;
		t_rx_own;
		t_rx_other;
		t_tmo;
		t_tx;
		t_bcast;
		conclude;
	end
endmodule
`default_nettype wire
